// ==== hdl/sfc_consts.vh ====
/*
  Constants for the serial frame controller of the sampling converter.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH
`define SFC_RES_BITS 14
`define SFC_DATA_LAST_RISE 5'h0D
`define SFC_WAKE_RISE 5'h08
`define SFC_SAMPLE_RISE 5'h09
`define SFC_SAMPLE_FALL 5'h10
`define SFC_ABORT_CODE 14'h3F80
`define SFC_RESULT_RESET 14'h0000
`define SFC_INVALID_CONV 3'h4
`define SFC_CLOCK_PERIOD_PS 5000
`define SFC_CONV_TIME_PS 365000
`define SFC_RESET_PHASE_PS 40000
`define SFC_PWD_ENTRY_PS 1000000
`define SFC_FLOAT_DELAY_PS 15000
`define SFC_WINDOW_DELAY_PS 5000
`endif

// ==== hdl/sfc_frame_control.v ====
/*
  Serial frame controller of a 14-bit sampling converter, with its result FIFO.
  Assumes one 200 MHz clock; serial clock, chip select, frame sync and the
  powerdown input come from outside and are synchronised here.
*/
`timescale 1ns/1ps
`include "sfc_consts.vh"
`default_nettype none

// ==========================================================================
// Result FIFO
module sfc_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clock,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full;
  wire empty;
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always @(posedge clock) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ==========================================================================
// Frame controller
// Summary of operation
// RULE1: Plain mode: frame sync held high, frame starts on chip select fall.
// RULE2: MSB shown at frame start; next bits on rising edges through the 14th. The code shifts only through the 13th rise.
// RULE3: Clock one is the cycle of first falling edge after frame start.
// RULE4: Nap from conversion end until 8th rising edge of next frame.
// RULE5: Tracking starts on 9th rising edge; conversion starts on 16th falling.
// RULE6: Busy high for whole conversion; new frame allowed after it ends.
// RULE7: Sync mode: chip select held low, frame starts on frame sync rise.
// RULE8: Sync mode host may raise chip select after 16th falling edge.
// RULE9: Powerdown input low acts asynchronously, entering a timed reset phase. The code enters it through the two-flop synchroniser.
// RULE10: Data output floats within output float delay after powerdown falls.
// RULE11: Powerdown held past entry time moves device into full powerdown.
// RULE12: First four conversions after powerup or reset are flagged invalid.
// RULE13: Phases: data first 8 clocks, sample 9th rise to 16th fall, convert.
// RULE14: Plain mode chip select rise before 9th rising edge aborts frame.
// RULE15: After early abort the earlier result is sent again next frame.
// RULE16: Plain mode chip select rise in sample window starts conversion at once.
// RULE17: Data output is high impedance whenever chip select is high.
// RULE18: Plain mode chip select fall while busy aborts conversion, starts frame.
// RULE19: First frame after conversion abort shifts out fixed code 3F80.
// RULE20: Sync mode frame sync or chip select rise before 9th rise aborts.
// RULE21: Sync mode rise in sample window starts conversion, cuts data transfer.
// RULE22: Sync mode frame sync rise aborts conversion; chip select toggles ignored.
// RULE23: Host gives at least 16 serial clocks; may stop after 16th fall.
// RULE24: Conversion timed internally, finishing within 365 ns.
// RULE25: Result is 14-bit straight binary, zero to all ones.
// RULE26: Edge counter cleared at every frame start, including abort-started frames.
module sfc_frame_control #(
  parameter RES_BITS = `SFC_RES_BITS,
  parameter FIFO_DEPTH = 4,
  parameter PWD_ENTRY_CYCLES = (`SFC_PWD_ENTRY_PS / `SFC_CLOCK_PERIOD_PS)
) (
  input wire clock,
  input wire reset_n,
  input wire serial_clock,
  input wire chip_select_n,
  input wire frame_sync,
  input wire powerdown_reset_n,
  input wire [RES_BITS-1:0] sample_code,
  output reg sdo_out,
  output wire sdo_oe_n,
  output reg busy,
  output reg nap,
  output reg tracking,
  output reg powered_down,
  output reg in_reset_phase,
  output wire result_valid,
  input wire result_ready,
  output wire [RES_BITS-1:0] result_data,
  output wire result_invalid
);
  localparam CONV_CYCLES = `SFC_CONV_TIME_PS / `SFC_CLOCK_PERIOD_PS;
  localparam RESET_CYCLES = (`SFC_RESET_PHASE_PS + `SFC_CLOCK_PERIOD_PS - 1) /
                            `SFC_CLOCK_PERIOD_PS;
  localparam FLOAT_CYCLES = `SFC_FLOAT_DELAY_PS / `SFC_CLOCK_PERIOD_PS;
  localparam WIN_CYCLES = (`SFC_WINDOW_DELAY_PS + `SFC_CLOCK_PERIOD_PS - 1) /
                          `SFC_CLOCK_PERIOD_PS;
  localparam ST_IDLE = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_SAMPLE = 2'h2;
  localparam ST_CONV = 2'h3;

  // ========================================================================
  // Synchronisers
  reg [1:0] sclk_s;
  reg [1:0] cs_s;
  reg [1:0] fs_s;
  reg [1:0] pwd_s;
  reg sclk_d;
  reg cs_d;
  reg fs_d;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_s <= 2'h0;
      cs_s <= 2'h3;
      fs_s <= 2'h3;
      pwd_s <= 2'h3;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
      fs_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], serial_clock};
      cs_s <= {cs_s[0], chip_select_n};
      fs_s <= {fs_s[0], frame_sync};
      pwd_s <= {pwd_s[0], powerdown_reset_n};
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
      fs_d <= fs_s[1];
    end
  end
  wire sclk_rise = sclk_s[1] & ~sclk_d;
  wire sclk_fall = ~sclk_s[1] & sclk_d;
  wire cs_rise = cs_s[1] & ~cs_d;
  wire cs_fall = ~cs_s[1] & cs_d;
  wire fs_rise = fs_s[1] & ~fs_d;
  wire fs_fall = ~fs_s[1] & fs_d;
  wire pwd_low = ~pwd_s[1];
  // Sync mode is recognised by frame sync falling while chip select is low.
  reg sync_mode;

  // ========================================================================
  // Powerdown and reset phase
  // Raw powerdown and select pins reach only the output enable, so the pin floats at once.
  reg [31:0] pwd_count;
  reg [2:0] invalid_left;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pwd_count <= 32'h0;
      in_reset_phase <= 1'b0;
      powered_down <= 1'b0;
    end else if (pwd_low) begin
      if (pwd_count != 32'hFFFFFFFF) begin
        pwd_count <= pwd_count + 32'h1;
      end
      in_reset_phase <= (pwd_count < RESET_CYCLES); // RULE9
      powered_down <= (pwd_count >= PWD_ENTRY_CYCLES); // RULE11
    end else begin
      pwd_count <= 32'h0;
      in_reset_phase <= 1'b0;
      powered_down <= 1'b0;
    end
  end

  // ========================================================================
  // Frame sequencing
  reg [1:0] state;
  reg [4:0] rise_count;
  reg [4:0] fall_count;
  reg counting;
  reg [RES_BITS-1:0] shift;
  reg [RES_BITS-1:0] last_result;
  reg [8:0] conv_timer;
  reg [2:0] win_timer;
  reg push;
  reg [RES_BITS-1:0] push_data;
  reg cut_data;
  wire fifo_ready;
  wire plain_start = ~sync_mode & cs_fall; // RULE1
  wire sync_start = sync_mode & fs_rise & ~cs_s[1]; // RULE7
  wire conv_start_abort = (state == ST_CONV) & busy & (plain_start | sync_start); // RULE18 RULE22
  wire frame_start = plain_start | sync_start;
  wire early_abort = (state == ST_DATA) &
                     (sync_mode ? (fs_rise | cs_rise) : cs_rise); // RULE14 RULE20
  wire sample_abort = (state == ST_SAMPLE) & (win_timer == 3'h0) &
                      (sync_mode ? (fs_rise | cs_rise) : cs_rise); // RULE16 RULE21
  wire [RES_BITS-1:0] abort_code = `SFC_ABORT_CODE;
  wire [RES_BITS-1:0] next_load = last_result; // RULE15

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      sync_mode <= 1'b0;
      rise_count <= 5'h0;
      fall_count <= 5'h0;
      counting <= 1'b0;
      shift <= `SFC_RESULT_RESET;
      last_result <= `SFC_RESULT_RESET;
      conv_timer <= 9'h0;
      win_timer <= 3'h0;
      busy <= 1'b0;
      nap <= 1'b1;
      tracking <= 1'b0;
      sdo_out <= 1'b0;
      push <= 1'b0;
      push_data <= `SFC_RESULT_RESET;
      cut_data <= 1'b0;
      invalid_left <= `SFC_INVALID_CONV;
    end else if (pwd_low) begin
      state <= ST_IDLE; // RULE9
      busy <= 1'b0;
      tracking <= 1'b0;
      nap <= 1'b1;
      push <= 1'b0;
      counting <= 1'b0;
      invalid_left <= `SFC_INVALID_CONV; // RULE12
    end else begin
      push <= 1'b0;
      if (fs_fall && !cs_s[1]) begin
        sync_mode <= 1'b1;
      end else if (cs_fall && fs_s[1]) begin
        sync_mode <= 1'b0;
      end
      if (conv_start_abort || (frame_start && state == ST_IDLE) ||
          (frame_start && state == ST_DATA && !sync_mode)) begin
        if (conv_start_abort) begin
          shift <= abort_code; // RULE19
          sdo_out <= abort_code[RES_BITS-1];
          busy <= 1'b0;
        end else begin
          shift <= next_load;
          sdo_out <= next_load[RES_BITS-1]; // RULE2
        end
        state <= ST_DATA;
        rise_count <= 5'h0; // RULE26
        fall_count <= 5'h0;
        counting <= 1'b0;
        cut_data <= 1'b0;
      end else if (early_abort) begin
        state <= sync_mode && fs_rise ? ST_DATA : ST_IDLE; // RULE20
        shift <= last_result; // RULE15
        sdo_out <= last_result[RES_BITS-1];
        rise_count <= 5'h0; // RULE26
        fall_count <= 5'h0;
        counting <= 1'b0;
      end else if (sample_abort) begin
        state <= ST_CONV; // RULE16 RULE21
        tracking <= 1'b0;
        busy <= 1'b1;
        conv_timer <= 9'h0;
        cut_data <= (rise_count < `SFC_DATA_LAST_RISE + 5'h1); // RULE21
      end else begin
        if (state == ST_SAMPLE && win_timer != 3'h0) begin
          win_timer <= win_timer - 3'h1;
        end
        if ((state == ST_DATA || state == ST_SAMPLE) && sclk_fall) begin
          counting <= 1'b1; // RULE3
          if (fall_count != 5'h1F) begin
            fall_count <= fall_count + 5'h1;
          end
          if (state == ST_SAMPLE && fall_count + 5'h1 == `SFC_SAMPLE_FALL) begin
            state <= ST_CONV; // RULE5 RULE13
            tracking <= 1'b0;
            busy <= 1'b1; // RULE6
            conv_timer <= 9'h0;
          end
        end
        if ((state == ST_DATA || state == ST_SAMPLE) && sclk_rise && counting) begin
          rise_count <= rise_count + 5'h1;
          if (rise_count + 5'h1 <= `SFC_DATA_LAST_RISE && !cut_data) begin
            shift <= {shift[RES_BITS-2:0], 1'b0};
            sdo_out <= shift[RES_BITS-2]; // RULE2
          end
          if (rise_count + 5'h1 == `SFC_WAKE_RISE) begin
            nap <= 1'b0; // RULE4
          end
          if (rise_count + 5'h1 == `SFC_SAMPLE_RISE) begin
            state <= ST_SAMPLE; // RULE5 RULE13
            tracking <= 1'b1;
            win_timer <= WIN_CYCLES[2:0];
          end
        end
        if (state == ST_CONV) begin
          if (conv_timer == CONV_CYCLES[8:0] - 9'h1) begin
            state <= ST_IDLE; // RULE24
            busy <= 1'b0; // RULE6
            nap <= 1'b1; // RULE4
            last_result <= sample_code; // RULE25
            push_data <= sample_code;
            push <= fifo_ready;
            if (invalid_left != 3'h0) begin
              invalid_left <= invalid_left - 3'h1; // RULE12
            end
          end else begin
            conv_timer <= conv_timer + 9'h1;
          end
        end
      end
    end
  end

  // ========================================================================
  // Output float: a counter reaches the float delay; raw pin gives instant float.
  reg [3:0] float_count;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      float_count <= 4'h0;
    end else if (pwd_low && float_count < FLOAT_CYCLES[3:0]) begin
      float_count <= float_count + 4'h1; // RULE10
    end else if (!pwd_low) begin
      float_count <= 4'h0;
    end
  end
  assign sdo_oe_n = chip_select_n | cs_s[1] | ~powerdown_reset_n | pwd_low | // RULE17 RULE10
                    (float_count != 4'h0);

  // Results wait here for a consumer; a full FIFO drops the newest result.
  sfc_fifo #(
    .WIDTH(RES_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );
  assign result_invalid = (invalid_left != 3'h0);
endmodule
`default_nettype wire

// ==== verification/sfc_frame_control_monitor.sv ====
/*
  Port checker for the serial frame controller.
  Assumes a bind from the bench and pins that never move on a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
// =====
// Checker
module sfc_fc_monitor #(
  parameter PWD_ENTRY_CYCLES = 20
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic powerdown_reset_n,
  input wire logic sdo_oe_n,
  input wire logic busy,
  input wire logic nap,
  input wire logic tracking,
  input wire logic powered_down,
  input wire logic in_reset_phase
);
  int low_cnt;
  // Saturates so a long powerdown cannot wrap the count.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) low_cnt <= 0;
    else if (powerdown_reset_n) low_cnt <= 0;
    else if (low_cnt < PWD_ENTRY_CYCLES + 99) low_cnt <= low_cnt + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_oe_cs_high: assert property (chip_select_n |-> sdo_oe_n)
    else $error("data driven with select high");
  a_oe_pwd_low: assert property (!powerdown_reset_n |-> sdo_oe_n)
    else $error("data driven in powerdown");
  a_reset_entry: assert property ($fell(powerdown_reset_n) |-> ##[1:6] in_reset_phase)
    else $error("no reset phase");
  a_reset_stops_busy: assert property (in_reset_phase |-> ##[0:12] !busy)
    else $error("conversion survives reset");
  a_entry_early: assert property ($rose(powered_down) |-> low_cnt >= PWD_ENTRY_CYCLES)
    else $error("powerdown too early");
  a_entry_late: assert property (low_cnt == PWD_ENTRY_CYCLES + 8 |-> powered_down)
    else $error("powerdown too late");
  a_track_awake: assert property (tracking |-> !nap)
    else $error("tracking while napping");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:80] !busy)
    else $error("conversion too long");
  a_busy_from_track: assert property ($rose(busy) |-> $past(tracking) && !tracking)
    else $error("conversion without sampling");
endmodule
`default_nettype wire

// ==== verification/sfc_host_model.sv ====
/*
  Host serial port model driving select, frame sync and serial clock.
  Assumes go pulses only when the previous frame reported done.
*/
`timescale 1ns/1ps
`default_nettype none
// =====
// Host
module sfc_host_model (
  input wire logic go,
  input wire logic sync_mode,
  input wire logic [4:0] n_falls,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  output logic serial_clock,
  output logic chip_select_n,
  output logic frame_sync,
  output logic done,
  output logic [13:0] word
);
  // One process owns every pin; the serial clock stands high between frames.
  initial begin
    serial_clock = 1'b1;
    chip_select_n = 1'b1;
    frame_sync = 1'b1;
    done = 1'b0;
    word = 14'h0000;
    forever begin
      @(posedge go);
      done = 1'b0;
      if (sync_mode) begin
        if (chip_select_n) begin
          frame_sync = 1'b0;
          #24 chip_select_n = 1'b0;
          #48;
        end
        frame_sync = 1'b1;
        #24 frame_sync = 1'b0;
      end else chip_select_n = 1'b0;
      #24;
      for (int i = 1; i <= n_falls; i++) begin
        serial_clock = 1'b0;
        if (i <= 14) word = {word[12:0], sdo_oe_n ? ~word[0] : sdo_out};
        #24 serial_clock = 1'b1;
        #24;
      end
      chip_select_n = 1'b1;
      #48;
      if (sync_mode) chip_select_n = 1'b0;
      done = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== verification/test_sfc_frame_control.sv ====
/*
  Self-checking bench for the serial frame controller.
  Assumes the host model for the pins and a bound port checker.
*/
`timescale 1ns/1ps
`include "sfc_consts.vh"
`default_nettype none
// =====
// Bench
module test_sfc_frame_control;
  logic clock, reset_n, powerdown_reset_n, result_ready, go, sync_mode, done;
  logic serial_clock, chip_select_n, frame_sync, sdo_out, sdo_oe_n, busy, nap;
  logic tracking, powered_down, in_reset_phase, result_valid, result_invalid;
  logic inv_on, inv_exp;
  logic [4:0] n_falls;
  logic [13:0] sample_code, result_data, word, last;
  logic [13:0] q [0:3];
  int n_errors = 0;
  int tests_run = 0;
  int i;
  always #2.5 clock = ~clock;
  sfc_frame_control #(.PWD_ENTRY_CYCLES(20)) dut_u (.clock(clock), .reset_n(reset_n),
    .serial_clock(serial_clock), .chip_select_n(chip_select_n), .frame_sync(frame_sync),
    .powerdown_reset_n(powerdown_reset_n), .sample_code(sample_code), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .busy(busy), .nap(nap), .tracking(tracking),
    .powered_down(powered_down), .in_reset_phase(in_reset_phase),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
    .result_invalid(result_invalid));
  sfc_host_model host_u (.go(go), .sync_mode(sync_mode), .n_falls(n_falls),
    .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .serial_clock(serial_clock),
    .chip_select_n(chip_select_n), .frame_sync(frame_sync), .done(done), .word(word));
  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Selector 0 waits on the host's done flag, 1 on busy.
  task automatic wait_on(input int sel, input logic v);
    int k;
    k = 0;
    while ((sel == 0 ? done : busy) !== v) begin
      if (k == 400) begin
        n_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        stop_test;
      end
      @(negedge clock);
      k++;
    end
  endtask
  // Result expected from a frame; an aborted conversion shows the fixed code.
  function automatic logic [13:0] exp_word(input logic aborted);
    return aborted ? `SFC_ABORT_CODE : last;
  endfunction
  task automatic frame(input logic sm, input logic [4:0] nf, input logic wt, input logic chk,
                       input logic [13:0] expw);
    sample_code = 14'($urandom);
    sync_mode = sm;
    n_falls = nf;
    go = 1'b1;
    @(negedge clock);
    go = 1'b0;
    wait_on(0, 1'b1);
    if (chk) check(word, expw);
    if (inv_on) check({13'h0, result_invalid}, {13'h0, inv_exp});
    if (wt) begin
      wait_on(1, 1'b1);
      wait_on(1, 1'b0);
      last = sample_code;
    end
  endtask
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    powerdown_reset_n = 1'b1;
    result_ready = 1'b0;
    go = 1'b0;
    sync_mode = 1'b0;
    n_falls = 5'h10;
    sample_code = 14'h0000;
    last = `SFC_RESULT_RESET;
    inv_on = 1'b1;
    inv_exp = 1'b1;
    void'($urandom(46628));
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    // The far side stalls while six results arrive; the last two are dropped.
    for (i = 0; i < 6; i++) begin
      inv_exp = (i < 4);
      frame(1'b0, 5'h10, 1'b1, 1'b1, exp_word(1'b0));
      if (i < 4) q[i] = last;
    end
    check({13'h0, result_valid}, 14'h0001);
    for (i = 0; i < 4; i++) begin
      check(result_data, q[i]);
      result_ready = 1'b1;
      @(negedge clock);
      result_ready = 1'b0;
      @(negedge clock);
    end
    check({13'h0, result_valid}, 14'h0000);
    result_ready = 1'b1;
    inv_on = 1'b0;
    frame(1'b0, 5'h05, 1'b0, 1'b0, 14'h0000);
    check({13'h0, busy}, 14'h0000);
    frame(1'b0, 5'h10, 1'b1, 1'b1, exp_word(1'b0));
    frame(1'b0, 5'h0C, 1'b1, 1'b0, 14'h0000);
    frame(1'b0, 5'h10, 1'b0, 1'b1, exp_word(1'b0));
    frame(1'b0, 5'h10, 1'b1, 1'b1, exp_word(1'b1));
    powerdown_reset_n = 1'b0;
    repeat (4) @(negedge clock);
    check({12'h0, in_reset_phase, sdo_oe_n}, 14'h0003);
    repeat (40) @(negedge clock);
    check({13'h0, powered_down}, 14'h0001);
    powerdown_reset_n = 1'b1;
    repeat (20) @(negedge clock);
    inv_on = 1'b1;
    for (i = 0; i < 5; i++) begin
      inv_exp = (i < 4);
      frame(1'b0, 5'h10, 1'b1, i > 0, exp_word(1'b0));
    end
    inv_on = 1'b0;
    frame(1'b1, 5'h10, 1'b1, 1'b0, 14'h0000);
    frame(1'b1, 5'h10, 1'b1, 1'b1, exp_word(1'b0));
    frame(1'b1, 5'h05, 1'b0, 1'b0, 14'h0000);
    frame(1'b1, 5'h10, 1'b1, 1'b1, exp_word(1'b0));
    frame(1'b1, 5'h0C, 1'b1, 1'b0, 14'h0000);
    frame(1'b1, 5'h10, 1'b0, 1'b1, exp_word(1'b0));
    frame(1'b1, 5'h10, 1'b1, 1'b1, exp_word(1'b1));
    stop_test;
  end
endmodule
bind sfc_frame_control sfc_fc_monitor #(.PWD_ENTRY_CYCLES(PWD_ENTRY_CYCLES)) mon_u (
  .clock(clock), .reset_n(reset_n), .chip_select_n(chip_select_n),
  .powerdown_reset_n(powerdown_reset_n), .sdo_oe_n(sdo_oe_n), .busy(busy), .nap(nap),
  .tracking(tracking), .powered_down(powered_down), .in_reset_phase(in_reset_phase));
`default_nettype wire
